/* core/voice_session_ctrl.sv */
// session controller that hands the phone line to the voice verify unit
// Contract
// [RL1] session only when alarms go to primary
// [RL2] start after queue sent, alarm present
// [RL3] contact id sends listen-in event 606
// [RL4] receiver holds line one minute
// [RL5] release line, keep central call up
// [RL6] silence sirens and keypad sounds in session
// [RL7] restore keypads; sirens if timeout unexpired
// [RL8] session ends after 15 minutes maximum
// [RL9] fire drops line, reports, re-triggers
// [RL10] hold non-fire messages until session ends
// [RL11] falling-edge trigger to voice unit
// [RL12] zone 5 input marks session activity
// [RL13] zone 5 type voice, silencing enabled
// [RL14] trigger via aux select 3 or relay 60
// [RL15] trigger idles high, pulses low once
module voice_session_ctrl
  import voice_session_pkg::*;
#(
  parameter longint unsigned LIMIT_CYC = SESSION_LIMIT_CYC,
  parameter int unsigned     TRIG_CYC  = TRIG_LOW_CYC
) (
  input  wire logic        clock_in,
  input  wire logic        srst_in,
  input  wire logic        alarm_to_primary_in,
  input  wire logic [3:0]  primary_format_in,
  input  wire logic [3:0]  zone5_type_in,
  input  wire logic        silence_opt_in,
  input  wire logic [1:0]  aux_sel_in,
  input  wire logic [6:0]  relay_choice_in,
  input  wire logic        queue_done_in,
  input  wire logic        alarm_sent_in,
  input  wire logic        notice_done_in,
  input  wire logic        fire_alarm_in,
  input  wire logic        fire_report_done_in,
  input  wire logic        zone5_active_in,
  input  wire logic        alarm_timeout_in,
  output logic             send_notice_out,
  output logic [15:0]      notice_code_out,
  output logic             line_release_out,
  output logic             line_drop_out,
  output logic             send_fire_out,
  output logic             hold_reports_out,
  output logic             sirens_off_out,
  output logic             keypad_quiet_out,
  output logic             aux_trig_out,
  output logic             relay_trig_out,
  output logic             session_active_out
);
  // counter widths follow the chosen limits, so the full 15 minute default still fits
  localparam int unsigned LIMIT_W = $clog2(LIMIT_CYC + 64'd1);
  localparam int unsigned TRIG_W  = $clog2(64'(TRIG_CYC) + 64'd1);
  // trigger line 0 is the aux output, line 1 the relay
  localparam int unsigned N_TRIG  = 2;

  // talk phase: the unit owns the line and the sounders are quiet
  function automatic logic talk_state(input state_type s);
    talk_state = (s == ST_SESSION);
  endfunction : talk_state

  // states in which routine dialer traffic must wait; fire traffic is never held
  function automatic logic hold_state(input state_type s);
    hold_state = (s == ST_TRIG) || (s == ST_SESSION) || (s == ST_FIRE) || (s == ST_WAITEND);
  endfunction : hold_state

  state_type          state_q;
  state_type          state_d;
  logic [LIMIT_W-1:0] limit_cnt_q;
  logic [TRIG_W-1:0]  trig_cnt_q;
  logic               zone_seen_q;
  logic               sirens_off_q;
  logic               keypad_quiet_q;
  logic [N_TRIG-1:0]  trig_q;
  logic               notice_q;
  logic [15:0]        notice_code_q;
  logic               line_release_q;
  logic               line_drop_q;
  logic               send_fire_q;
  logic               hold_reports_q;
  logic               session_active_q;

  // configuration checks; a start failing the feature or trigger-select checks is simply ignored, the format only picks the notice
  wire feature_ok   = alarm_to_primary_in && (zone5_type_in == ZONE_TYPE_VOICE) && silence_opt_in; // [RL1] [RL13]
  wire use_aux      = (aux_sel_in == AUX_SEL_VOICE);            // [RL14]
  wire use_relay    = (relay_choice_in == RELAY_CHOICE_VOICE);  // [RL14]
  wire contact_id   = (primary_format_in == FORMAT_CONTACT_ID); // [RL3]
  wire start_ok     = feature_ok && queue_done_in && alarm_sent_in && (use_aux || use_relay); // [RL2]

  // timer and pulse decodes
  wire limit_hit    = (limit_cnt_q >= LIMIT_W'(LIMIT_CYC - 64'd1)); // [RL8]
  wire trig_done    = (trig_cnt_q >= TRIG_W'(TRIG_CYC - 32'd1));    // [RL15]
  wire in_session   = talk_state(state_q);
  // unit ends the session once zone 5 went active and then released;
  // a unit that never answers is only ended by the limit timer
  wire unit_done    = zone_seen_q && !zone5_active_in;               // [RL12]

  // decodes of the next state; every output flop is loaded from these
  wire next_notice  = (state_d == ST_NOTICE);
  wire next_trig    = (state_d == ST_TRIG);
  wire next_session = talk_state(state_d);
  wire next_fire    = (state_d == ST_FIRE);
  wire next_idle    = (state_d == ST_IDLE);
  wire next_hold    = hold_state(state_d);
  // the drop pulse marks only the step from the talk phase into fire
  wire fire_preempt = next_fire && in_session;                       // [RL9]
  wire [N_TRIG-1:0] trig_sel = {use_relay, use_aux};                 // [RL14]

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_ok) state_d = contact_id ? ST_NOTICE : ST_TRIG; // [RL2] [RL3]
      end
      ST_NOTICE: begin
        if (notice_done_in) state_d = ST_TRIG;
      end
      ST_TRIG: begin
        if (trig_done) state_d = ST_SESSION; // [RL15]
      end
      ST_SESSION: begin
        if (fire_alarm_in) state_d = ST_FIRE; // [RL9]
        else if (limit_hit || unit_done) state_d = ST_IDLE; // [RL8] [RL10]
      end
      ST_FIRE: begin
        if (fire_report_done_in) state_d = ST_WAITEND; // [RL9]
      end
      // one step with the line dropped before the unit is woken again
      ST_WAITEND: begin
        state_d = ST_TRIG; // [RL9]
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // session timer runs from leaving idle and survives a fire re-trigger, so the cap is total;
  // it saturates so a long fire report cannot wrap it back below the limit
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      limit_cnt_q <= '0;
    end else if (state_q == ST_IDLE) begin
      limit_cnt_q <= '0;
    end else if (!limit_hit) begin
      limit_cnt_q <= limit_cnt_q + LIMIT_W'(1); // [RL8]
    end
  end

  // trigger pulse length counter, cleared outside the trigger step
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      trig_cnt_q <= '0;
    end else begin
      trig_cnt_q <= (state_q == ST_TRIG) ? trig_cnt_q + TRIG_W'(1) : '0; // [RL15]
    end
  end

  // remembers that the unit has spoken, so a quiet zone before talk does not end the session
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      zone_seen_q <= 1'b0;
    end else begin
      zone_seen_q <= in_session && (zone_seen_q || zone5_active_in); // [RL12]
    end
  end

  // keypad sounds are quiet exactly while the unit talks
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      keypad_quiet_q <= 1'b0;
    end else begin
      keypad_quiet_q <= next_session; // [RL6] [RL7]
    end
  end

  // sirens come back at session end only while the alarm sounding time still runs;
  // once it has expired they stay off until the sounding time runs again while idle or at a session end, or a reset
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      sirens_off_q <= 1'b0;
    end else if (next_session) begin
      sirens_off_q <= 1'b1; // [RL6]
    end else if (next_idle) begin
      sirens_off_q <= sirens_off_q && !alarm_timeout_in; // [RL7]
    end
  end

  // trigger lines idle high; low for a fixed pulse gives one falling edge per trigger step, so a fire re-trigger gives a second
  for (genvar g = 0; g < N_TRIG; g++) begin : g_trig
    always_ff @(posedge clock_in) begin
      if (srst_in) begin
        trig_q[g] <= 1'b1;
      end else begin
        trig_q[g] <= !(next_trig && trig_sel[g]); // [RL11] [RL14] [RL15]
      end
    end
  end

  // listen-in notice request and its event code travel together
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      notice_q      <= 1'b0;
      notice_code_q <= 16'h0000;
    end else begin
      notice_q      <= next_notice;                              // [RL3]
      notice_code_q <= next_notice ? LISTEN_IN_CODE : 16'h0000;  // [RL3]
    end
  end

  // line handed to the unit while the central call stays up
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      line_release_q <= 1'b0;
    end else begin
      line_release_q <= next_session; // [RL5]
    end
  end

  // one-cycle drop of the call when a fire alarm cuts in
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      line_drop_q <= 1'b0;
    end else begin
      line_drop_q <= fire_preempt; // [RL9]
    end
  end

  // fire report request stands until the dialer says it went out
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      send_fire_q <= 1'b0;
    end else begin
      send_fire_q <= next_fire; // [RL9]
    end
  end

  // routine reports wait through trigger, talk and fire preemption
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      hold_reports_q <= 1'b0;
    end else begin
      hold_reports_q <= next_hold; // [RL10]
    end
  end

  // session status for the rest of the panel
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      session_active_q <= 1'b0;
    end else begin
      session_active_q <= next_session;
    end
  end

  // every output straight from its flop
  assign send_notice_out    = notice_q;
  assign notice_code_out    = notice_code_q;
  assign line_release_out   = line_release_q;
  assign line_drop_out      = line_drop_q;
  assign send_fire_out      = send_fire_q;
  assign hold_reports_out   = hold_reports_q;
  assign session_active_out = session_active_q;
  assign sirens_off_out     = sirens_off_q;
  assign keypad_quiet_out   = keypad_quiet_q;
  assign aux_trig_out       = trig_q[0];
  assign relay_trig_out     = trig_q[1];
endmodule : voice_session_ctrl

/* core/voice_session_pkg.sv */
// constants and types shared by the voice verification session controller
package voice_session_pkg;
  localparam int unsigned CLOCK_HZ           = 25_000_000;
  localparam int unsigned SESSION_LIMIT_MIN  = 15;
  // 15 minutes of clocks does not fit in 32 bits, so the cap is reckoned in 64
  localparam longint unsigned SESSION_LIMIT_CYC = 64'(SESSION_LIMIT_MIN) * 64'd60 * 64'(CLOCK_HZ);
  localparam int unsigned TRIG_LOW_NS        = 1_000_000;
  localparam int unsigned TRIG_LOW_CYC       = TRIG_LOW_NS / (32'd1_000_000_000 / CLOCK_HZ);
  localparam logic [15:0] LISTEN_IN_CODE     = 16'h0606;
  localparam logic [3:0]  ZONE_TYPE_VOICE    = 4'hA;
  localparam logic [1:0]  AUX_SEL_VOICE      = 2'h3;
  localparam logic [6:0]  RELAY_CHOICE_VOICE = 7'h3C;
  localparam logic [3:0]  FORMAT_CONTACT_ID  = 4'h1;
  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_NOTICE  = 6'h02,
    ST_TRIG    = 6'h04,
    ST_SESSION = 6'h08,
    ST_FIRE    = 6'h10,
    ST_WAITEND = 6'h20
  } state_type;
endpackage : voice_session_pkg

/* verif/voice_unit_model.sv */
// behavioural voice verify unit seen from the controller's trigger and zone 5 pins
module voice_unit_model (
  input  wire logic clock_in, trig_in, release_in, talk_in,
  output logic      zone5_active_out = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic trig_q = 1'h1, armed_q = 1'h0;
  // only a falling edge arms it; a level low alone would re-arm after each call
  always @(posedge clock_in) begin
    trig_q <= trig_in;
    armed_q <= (armed_q | (trig_q & ~trig_in)) & ~(zone5_active_out & ~talk_in);
    zone5_active_out <= armed_q & talk_in & release_in;
  end
endmodule : voice_unit_model

/* verif/voice_session_ctrl_monitor.sv */
// port checker for the voice session controller
module voice_session_ctrl_monitor (
  input wire logic clock_in, srst_in, send_notice_out, line_release_out, line_drop_out, send_fire_out,
  input wire logic hold_reports_out, sirens_off_out, keypad_quiet_out, aux_trig_out, relay_trig_out,
  input wire logic session_active_out,
  input wire logic [15:0] notice_code_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  sequence aux_fall; $fell(aux_trig_out); endsequence
  sequence relay_fall; $fell(relay_trig_out); endsequence
  AST_CODE: assert property (send_notice_out |-> notice_code_out == 16'h0606) else $error("code");
  AST_QUIET: assert property (line_release_out |-> sirens_off_out && keypad_quiet_out) else $error("loud");
  AST_HOLD: assert property (session_active_out |-> hold_reports_out) else $error("hold");
  AST_DROP: assert property (line_drop_out |=> !line_drop_out) else $error("drop");
  AST_AUX: assert property (aux_fall |=> !aux_trig_out [*8]) else $error("aux");
  AST_RELAY: assert property (relay_fall |=> !relay_trig_out [*8]) else $error("relay");
  AST_KEYPAD: assert property ($fell(session_active_out) |-> !keypad_quiet_out) else $error("keys");
  AST_FREE: assert property (line_release_out |-> aux_trig_out && relay_trig_out) else $error("line");
endmodule : voice_session_ctrl_monitor
bind voice_session_ctrl voice_session_ctrl_monitor mon_u (.*);

/* verif/alarm_voice_session_control_bench.sv */
// directed bench for the voice session controller
module alarm_voice_session_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import voice_session_pkg::*;
  logic clock_in = 0, srst_in = 1, alarm_to_primary_in = 1, silence_opt_in = 1, queue_done_in = 0, alarm_sent_in = 0;
  logic notice_done_in = 0, fire_alarm_in = 0, fire_report_done_in = 0, zone5_active_in, alarm_timeout_in = 0, talk = 0;
  logic [3:0] primary_format_in = 4'h0, zone5_type_in = ZONE_TYPE_VOICE;
  logic [1:0] aux_sel_in = AUX_SEL_VOICE;
  logic [6:0] relay_choice_in = 7'h00;
  logic send_notice_out, line_release_out, line_drop_out, send_fire_out, hold_reports_out, sirens_off_out;
  logic keypad_quiet_out, aux_trig_out, relay_trig_out, session_active_out;
  logic [15:0] notice_code_out;
  int n_errors = 0, check_count = 0, cyc = 0;
  // short limit and pulse keep the run small; the pulse still outlasts the monitor's 8-cycle window
  localparam int LIM = 2000;
  localparam int TRIG = 20;
  voice_session_ctrl #(.LIMIT_CYC(LIM), .TRIG_CYC(TRIG)) dut_u (.*);
  voice_unit_model unit_u (.clock_in, .trig_in(aux_trig_out & relay_trig_out), .release_in(line_release_out),
    .talk_in(talk), .zone5_active_out(zone5_active_in));
  initial forever #20 clock_in = ~clock_in;
  always @(posedge clock_in) cyc <= cyc + 1;
  task chk(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wt(input int n); repeat (n) @(posedge clock_in); endtask : wt
  task start(input logic alarm);
    @(posedge clock_in);
    queue_done_in <= 1;
    alarm_sent_in <= alarm;
    wt(1);
    queue_done_in <= 0;
    wt(4);
  endtask : start
  task wait_active(input logic v);
    for (int i = 0; i < 3000 && session_active_out !== v; i++) @(posedge clock_in);
    chk(session_active_out, v);
  endtask : wait_active
  task t_refuse;
    alarm_to_primary_in <= 0;
    start(1);
    chk(aux_trig_out, 1);
    alarm_to_primary_in <= 1;
    zone5_type_in <= 4'h3;
    start(1);
    chk(aux_trig_out, 1);
    zone5_type_in <= ZONE_TYPE_VOICE;
    aux_sel_in <= 2'h0;
    start(1);
    chk(aux_trig_out, 1);
    aux_sel_in <= AUX_SEL_VOICE;
    start(0);
    chk(aux_trig_out, 1);
    $display("refuse done");
  endtask : t_refuse
  task t_plain;
    start(1);
    chk(aux_trig_out, 0);
    chk(send_notice_out, 0);
    chk(hold_reports_out, 1);
    wait_active(1);
    chk(line_release_out, 1);
    chk(sirens_off_out, 1);
    chk(keypad_quiet_out, 1);
    chk(hold_reports_out, 1);
    talk <= 1;
    wt(6);
    talk <= 0;
    wt(4);
    chk(keypad_quiet_out, 0);
    chk(sirens_off_out, 1);
    chk(hold_reports_out, 0);
    chk(line_release_out, 0);
    $display("plain done");
  endtask : t_plain
  task t_fire;
    int t0;
    t0 = cyc;
    primary_format_in <= FORMAT_CONTACT_ID;
    alarm_timeout_in <= 1;
    aux_sel_in <= 2'h0;
    relay_choice_in <= RELAY_CHOICE_VOICE;
    start(1);
    chk(send_notice_out, 1);
    chk(notice_code_out, 16'h0606);
    chk(relay_trig_out, 1);
    notice_done_in <= 1; // receiver took the notice and holds the call open
    wt(1);
    notice_done_in <= 0;
    wait_active(1);
    chk(line_release_out, 1);
    fire_alarm_in <= 1;
    wt(1);
    fire_alarm_in <= 0;
    wt(1);
    chk(line_drop_out, 1);
    chk(line_release_out, 0);
    wt(1);
    chk(line_drop_out, 0);
    chk(send_fire_out, 1);
    chk(hold_reports_out, 1);
    fire_report_done_in <= 1;
    wt(1);
    fire_report_done_in <= 0;
    wt(2);
    chk(relay_trig_out, 0);
    wait_active(1);
    wait_active(0);
    chk(cyc - t0 >= LIM, 1);
    chk(cyc - t0 <= LIM + 8, 1);
    chk(hold_reports_out, 0);
    chk(sirens_off_out, 0);
    $display("fire done");
  endtask : t_fire
  task conclude;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  initial begin
    wt(16);
    srst_in <= 0;
    t_refuse;
    t_plain;
    t_fire;
    conclude;
  end
  initial begin
    // the tests need about LIM plus a hundred cycles; this leaves ample margin
    wt(6000);
    n_errors++;
    conclude;
  end
endmodule : alarm_voice_session_control_bench
